//--- inc/vds_pkg.sv
// Constants, timing counts and state type of the video DRAM sequencer
package vds_pkg;

	// ------------------------------------------------------------
	// Clock
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 4;

	// Figures in tenths of a memory or sequencer clock period; page time in us, refresh interval in ns
	localparam int T_RCD_X10 = 25;
	localparam int T_CAS_LO_X10 = 15;
	localparam int T_CAS_PRE_X10 = 5;
	localparam int T_RP_X10 = 30;
	localparam int T_WE_LEAD_X10 = 5;
	localparam int T_REF_CSR_X10 = 10;
	localparam int T_REF_RAS_X10 = 40;
	localparam int T_REF_RP_X10 = 30;
	localparam int T_REF_CPN_X10 = 20;
	localparam int PAGE_MAX_US = 32;
	localparam int REF_INTERVAL_NS = 15600;

	// Least times round up, never below one cycle
	function automatic int cyc_min(input int x10);
		int c;
		c = (x10 + 9) / 10;
		return (c < 1) ? 1 : c;
	endfunction

	// ------------------------------------------------------------
	// Timer loads (cycles minus one); WE_LEAD is a compare count in whole cycles
	// ------------------------------------------------------------
	localparam logic [3:0] RCD_LD = 4'(cyc_min(T_RCD_X10) - 1);
	localparam logic [3:0] CAS_LO_LD = 4'(cyc_min(T_CAS_LO_X10) - 1);
	localparam logic [3:0] CAS_PRE_LD = 4'(cyc_min(T_CAS_PRE_X10) - 1);
	localparam logic [3:0] RP_LD = 4'(cyc_min(T_RP_X10) - 1);
	localparam logic [3:0] WE_LEAD = 4'(cyc_min(T_WE_LEAD_X10));
	localparam logic [3:0] REF_CSR_LD = 4'(cyc_min(T_REF_CSR_X10) - 1);
	localparam logic [3:0] REF_RAS_LD = 4'(cyc_min(T_REF_RAS_X10) - 1);
	localparam logic [3:0] REF_RP_LD = 4'(cyc_min(T_REF_RP_X10) - 1);
	localparam logic [3:0] REF_END_LD =
		4'(((cyc_min(T_REF_CPN_X10) > cyc_min(T_REF_RP_X10)) ?
		cyc_min(T_REF_CPN_X10) : cyc_min(T_REF_RP_X10)) - 1);

	// Longest page time rounds down
	localparam int PAGE_MAX_CYC = PAGE_MAX_US * 1000 / CLK_PERIOD_NS;
	localparam int PAGE_GUARD = 8;
	localparam int REF_INTERVAL_CYC = REF_INTERVAL_NS / CLK_PERIOD_NS;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_RAS_ON = 4'h1,
		ST_CAS_ON = 4'h3,
		ST_CAS_OFF = 4'h7,
		ST_PRE = 4'h2,
		ST_REF_CAS = 4'h8,
		ST_REF_RLO = 4'hc,
		ST_REF_RHI = 4'hd,
		ST_REF_END = 4'h4
	} vds_state_t;

endpackage

//--- hdl/vds_sequencer.sv
// Video DRAM cycle sequencer: access, page mode, refresh, straps
`timescale 1ns/100ps

module vds_sequencer #(
	parameter int ROW_W = 9,
	parameter int COL_W = 9,
	parameter int DATA_W = 16,
	parameter int REF_PULSES = 4,
	parameter int PAGE_MAX = vds_pkg::PAGE_MAX_CYC,
	parameter int REF_INTERVAL = vds_pkg::REF_INTERVAL_CYC
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// Requestor side
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic [ROW_W+COL_W-1:0] req_addr,
	input wire logic [DATA_W-1:0] req_wdata,
	output logic req_ready,
	output logic rd_valid,
	output logic [DATA_W-1:0] rd_data,
	output logic [DATA_W-1:0] strap_cfg,
	// DRAM pins
	output logic dram_ras_n,
	output logic dram_cas_n,
	output logic dram_we_n,
	output logic dram_oe_n,
	output logic [ROW_W-1:0] dram_addr,
	input wire logic [DATA_W-1:0] md_in,
	output logic [DATA_W-1:0] md_out,
	output logic md_oe
);
	import vds_pkg::*;
	localparam int PW = $clog2(PAGE_MAX + 1);
	localparam int RW = $clog2(REF_INTERVAL + 1);
	localparam logic [PW-1:0] PAGE_LIM = PW'(PAGE_MAX - PAGE_GUARD);
	localparam logic [RW-1:0] REF_LD = RW'(REF_INTERVAL - 1);
	localparam logic [2:0] REF_LAST = 3'(REF_PULSES - 1);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	vds_state_t state_reg, state_next;
	logic [3:0] tmr_reg, tmr_next;
	logic ras_n_reg, ras_n_next, cas_n_reg, cas_n_next;
	logic we_n_reg, we_n_next, oe_n_reg, oe_n_next;
	logic md_oe_reg, md_oe_next, wr_reg, wr_next;
	logic rd_valid_reg, rd_valid_next, ref_pend_reg, ref_pend_next;
	logic strap_done_reg, strap_done_next;
	logic [ROW_W-1:0] addr_reg, addr_next, row_reg, row_next;
	logic [COL_W-1:0] col_reg, col_next;
	logic [DATA_W-1:0] md_out_reg, md_out_next, wdata_reg, wdata_next;
	logic [DATA_W-1:0] rd_data_reg, rd_data_next, strap_reg, strap_next;
	logic [PW-1:0] page_cnt_reg, page_cnt_next;
	logic [RW-1:0] ref_cnt_reg, ref_cnt_next;
	logic [2:0] ref_num_reg, ref_num_next;
	logic idle_take, page_take, ref_start;
	function automatic logic [ROW_W-1:0] row_of(
		input logic [ROW_W+COL_W-1:0] a);
		return a[ROW_W+COL_W-1:COL_W];
	endfunction
	// ------------------------------------------------------------
	// Request acceptance
	// ------------------------------------------------------------
	// Refresh has priority once the bank is precharged
	assign idle_take = (state_reg == ST_IDLE) && !ref_pend_reg;
	// Same row and direction only, to keep the read command hold
	assign page_take = (state_reg == ST_CAS_ON) && (tmr_reg == 4'h0) &&
		req_valid && !ref_pend_reg && (req_write == wr_reg) &&
		(row_of(req_addr) == row_reg) &&
		(page_cnt_reg < PAGE_LIM);
	assign req_ready = idle_take || page_take;
	assign ref_start = (state_reg == ST_IDLE) && ref_pend_reg;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		{tmr_next, page_cnt_next, ref_num_next} =
			{tmr_reg, page_cnt_reg, ref_num_reg};
		{ras_n_next, cas_n_next, we_n_next, oe_n_next, md_oe_next} =
			{ras_n_reg, cas_n_reg, we_n_reg, oe_n_reg, md_oe_reg};
		{addr_next, md_out_next, row_next, col_next} =
			{addr_reg, md_out_reg, row_reg, col_reg};
		{wr_next, wdata_next, rd_data_next} =
			{wr_reg, wdata_reg, rd_data_reg};
		rd_valid_next = 1'b0;
		if (!ras_n_reg && state_reg != ST_REF_RLO) begin
			page_cnt_next = page_cnt_reg + 1'b1;
		end
		case (state_reg)
		ST_IDLE: begin
			if (ref_pend_reg) begin
				state_next = ST_REF_CAS;
				cas_n_next = 1'b0;
				tmr_next = REF_CSR_LD;
				ref_num_next = 3'h0;
			end else if (req_valid) begin
				state_next = ST_RAS_ON;
				ras_n_next = 1'b0;
				addr_next = row_of(req_addr);
				row_next = row_of(req_addr);
				col_next = req_addr[COL_W-1:0];
				wr_next = req_write;
				wdata_next = req_wdata;
				tmr_next = RCD_LD;
				page_cnt_next = '0;
			end
		end
		ST_RAS_ON: begin
			// Row stays on the pins for the first clock only
			addr_next = col_reg;
			if (wr_reg && tmr_reg == WE_LEAD) begin
				we_n_next = 1'b0;
				md_oe_next = 1'b1;
				md_out_next = wdata_reg;
			end
			if (tmr_reg == 4'h0) begin
				state_next = ST_CAS_ON;
				cas_n_next = 1'b0;
				oe_n_next = wr_reg;
				tmr_next = CAS_LO_LD;
			end else begin
				tmr_next = tmr_reg - 1'b1;
			end
		end
		ST_CAS_ON: begin
			if (tmr_reg != 4'h0) begin
				tmr_next = tmr_reg - 1'b1;
			end else begin
				if (!wr_reg) begin
					// Data sampled two clocks after CAS and OE fall
					rd_valid_next = 1'b1;
					rd_data_next = md_in;
				end
				// Write data and WE held through the CAS low
				cas_n_next = 1'b1;
				oe_n_next = 1'b1;
				we_n_next = 1'b1;
				md_oe_next = 1'b0;
				if (page_take) begin
					state_next = ST_CAS_OFF;
					col_next = req_addr[COL_W-1:0];
					addr_next = req_addr[COL_W-1:0];
					tmr_next = CAS_PRE_LD;
					if (wr_reg) begin
						we_n_next = 1'b0;
						md_oe_next = 1'b1;
						md_out_next = req_wdata;
					end
				end else begin
					state_next = ST_PRE;
					ras_n_next = 1'b1;
					tmr_next = RP_LD;
				end
			end
		end
		ST_CAS_OFF: begin
			if (tmr_reg == 4'h0) begin
				state_next = ST_CAS_ON;
				cas_n_next = 1'b0;
				oe_n_next = wr_reg;
				tmr_next = CAS_LO_LD;
			end else begin
				tmr_next = tmr_reg - 1'b1;
			end
		end
		ST_PRE: begin
			if (tmr_reg == 4'h0) begin
				state_next = ST_IDLE;
			end else begin
				tmr_next = tmr_reg - 1'b1;
			end
		end
		ST_REF_CAS, ST_REF_RHI: begin
			if (tmr_reg == 4'h0) begin
				state_next = ST_REF_RLO;
				ras_n_next = 1'b0;
				tmr_next = REF_RAS_LD;
			end else begin
				tmr_next = tmr_reg - 1'b1;
			end
		end
		ST_REF_RLO: begin
			if (tmr_reg == 4'h0) begin
				ras_n_next = 1'b1;
				ref_num_next = ref_num_reg + 1'b1;
				if (ref_num_reg == REF_LAST) begin
					state_next = ST_REF_END;
					cas_n_next = 1'b1;
					tmr_next = REF_END_LD;
				end else begin
					state_next = ST_REF_RHI;
					tmr_next = REF_RP_LD;
				end
			end else begin
				tmr_next = tmr_reg - 1'b1;
			end
		end
		ST_REF_END: begin
			if (tmr_reg == 4'h0) begin
				state_next = ST_IDLE;
			end else begin
				tmr_next = tmr_reg - 1'b1;
			end
		end
		default: begin
			state_next = ST_IDLE;
			ras_n_next = 1'b1;
			cas_n_next = 1'b1;
			we_n_next = 1'b1;
			oe_n_next = 1'b1;
			md_oe_next = 1'b0;
		end
		endcase
	end
	// Refresh timer; a new tick wins over the start of a burst
	always_comb begin
		ref_cnt_next = ref_cnt_reg - 1'b1;
		ref_pend_next = ref_pend_reg && !ref_start;
		if (ref_cnt_reg == '0) begin
			ref_cnt_next = REF_LD;
			ref_pend_next = 1'b1;
		end
	end
	// Straps taken on the first clock after reset release
	always_comb begin
		strap_done_next = 1'b1;
		strap_next = strap_done_reg ? strap_reg : md_in;
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg <= ST_IDLE;
			{tmr_reg, page_cnt_reg, ref_num_reg} <= '0;
			{ras_n_reg, cas_n_reg, we_n_reg, oe_n_reg} <= 4'hf;
			{md_oe_reg, addr_reg, md_out_reg} <= '0;
			{row_reg, col_reg, wr_reg, wdata_reg} <= '0;
			{rd_valid_reg, rd_data_reg} <= '0;
			{ref_pend_reg, strap_reg, strap_done_reg} <= '0;
			ref_cnt_reg <= REF_LD;
		end else begin
			state_reg <= state_next;
			{tmr_reg, page_cnt_reg, ref_num_reg} <=
				{tmr_next, page_cnt_next, ref_num_next};
			{ras_n_reg, cas_n_reg, we_n_reg, oe_n_reg} <=
				{ras_n_next, cas_n_next, we_n_next, oe_n_next};
			{md_oe_reg, addr_reg, md_out_reg} <=
				{md_oe_next, addr_next, md_out_next};
			{row_reg, col_reg, wr_reg, wdata_reg} <=
				{row_next, col_next, wr_next, wdata_next};
			{rd_valid_reg, rd_data_reg} <=
				{rd_valid_next, rd_data_next};
			{ref_cnt_reg, ref_pend_reg} <= {ref_cnt_next, ref_pend_next};
			{strap_reg, strap_done_reg} <= {strap_next, strap_done_next};
		end
	end

	assign {dram_ras_n, dram_cas_n} = {ras_n_reg, cas_n_reg};
	assign {dram_we_n, dram_oe_n} = {we_n_reg, oe_n_reg};
	assign dram_addr = addr_reg;
	assign {md_out, md_oe} = {md_out_reg, md_oe_reg};
	assign {rd_valid, rd_data} = {rd_valid_reg, rd_data_reg};
	assign strap_cfg = strap_reg;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_b);
	a_rcd_delay: assert property ($fell(ras_n_reg) && cas_n_reg |->
		cas_n_reg [*3]) else $error("CAS fell too soon after RAS");
	a_row_hold: assert property ($fell(ras_n_reg) && cas_n_reg |->
		addr_reg == row_reg) else $error("row address not on pins");
	a_col_hold: assert property ($fell(cas_n_reg) && !ras_n_reg |->
		##1 $stable(addr_reg)) else $error("column address changed");
	a_ras_pre: assert property ($rose(ras_n_reg) |->
		ras_n_reg [*3]) else $error("RAS precharge too short");
	a_ras_low: assert property ($fell(ras_n_reg) |->
		!ras_n_reg [*4]) else $error("RAS low pulse too short");
	a_page_limit: assert property (page_cnt_reg < PW'(PAGE_MAX))
		else $error("page open too long");
	a_cas_low: assert property ($fell(cas_n_reg) && !ras_n_reg |->
		!cas_n_reg [*2]) else $error("CAS low pulse too short");
	a_cas_first: assert property ($fell(ras_n_reg) && cas_n_reg |->
		$past(cas_n_reg)) else $error("CAS not high before RAS");
	a_ras_oe: assert property ($fell(oe_n_reg) |->
		!ras_n_reg [*2]) else $error("RAS rose too soon after OE");
	a_we_setup: assert property ($fell(cas_n_reg) && !we_n_reg |->
		!$past(we_n_reg) ##1 !we_n_reg) else $error("WE setup or hold");
	a_wdata_hold: assert property ($fell(cas_n_reg) && !we_n_reg |->
		md_oe_reg ##1 md_oe_reg && $stable(md_out_reg))
		else $error("write data not held");
	a_cbr_order: assert property ($fell(ras_n_reg) && !cas_n_reg |->
		!$past(cas_n_reg)) else $error("refresh CAS not first");
	a_ref_count: assert property ($rose(cas_n_reg) &&
		state_reg == ST_REF_END |-> ref_num_reg == 3'(REF_PULSES))
		else $error("wrong refresh pulse count");
	a_ref_end: assert property ($rose(cas_n_reg) &&
		state_reg == ST_REF_END |-> cas_n_reg [*3])
		else $error("refresh CAS precharge too short");
	c_read: cover property (rd_valid_reg);
	c_write: cover property ($fell(cas_n_reg) && !we_n_reg);
	c_page: cover property (state_reg == ST_CAS_OFF);
	c_refresh: cover property (state_reg == ST_REF_END);
endmodule

//--- test/vds_dram_model.sv
// Behavioural 16-bit video DRAM that sits on the sequencer's memory pins
`timescale 1ns/100ps

module vds_dram_model (
	// Clock
	input wire logic sys_clk,
	// Strobes and address
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic oe_n,
	input wire logic [8:0] addr,
	// Data pins
	input wire logic [15:0] din,
	input wire logic din_en,
	output logic [15:0] dq
);
	logic [15:0] mem [int];
	logic [8:0] row = 9'h0;
	logic [8:0] col = 9'h0;
	logic ras_q = 1'b1;
	logic cas_q = 1'b1;

	initial dq = 16'h0;

	// Pins are looked at mid-cycle, where the sequencer's outputs are settled
	always @(negedge sys_clk) begin
		if (!ras_n && ras_q && cas_n)
			row = addr;
		if (!cas_n && cas_q && !ras_n) begin
			col = addr;
			if (!we_n && din_en)
				mem[{row, col}] = din;
		end
		// Undriven bus toggles so a late sample never passes by chance
		if (!oe_n && !cas_n && we_n)
			dq <= mem.exists({row, col}) ? mem[{row, col}] : 16'h0;
		else
			dq <= ~dq;
		ras_q <= ras_n;
		cas_q <= cas_n;
	end
endmodule

//--- test/video_dram_cycle_sequencer_test.sv
// Self-checking bench for the video DRAM cycle sequencer
`timescale 1ns/100ps

module video_dram_cycle_sequencer_test;
	import vds_pkg::*;
	localparam int REF_P = 4;
	localparam int PG = 40;
	logic sys_clk, rst_b, req_valid, req_write, req_ready, rd_valid, md_oe;
	logic dram_ras_n, dram_cas_n, dram_we_n, dram_oe_n, strap_drv;
	logic ras_q = 1'b1;
	logic cas_q = 1'b1;
	logic we_q = 1'b1;
	logic [17:0] req_addr;
	logic [15:0] req_wdata, rd_data, strap_cfg, md_in, md_out, mdl_q, strap;
	logic [8:0] dram_addr;
	int err_count = 0;
	int n_checks = 0;
	int cyc = 0;
	int n_ref = 0;
	int ref_p = 0;
	int ras_lo = 0;
	int ras_hi = 99;
	int cas_lo = 0;
	int cas_hi = 99;
	logic [15:0] ref_m [int];
	logic [15:0] exp_q [$];
	int lat_q [$];

	// Straps are driven onto the data pins only around reset release
	assign md_in = strap_drv ? strap : mdl_q;

	vds_sequencer #(.REF_PULSES(REF_P), .PAGE_MAX(PG), .REF_INTERVAL(200)) i_dut (
		.sys_clk(sys_clk), .rst_b(rst_b), .req_valid(req_valid),
		.req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
		.req_ready(req_ready), .rd_valid(rd_valid), .rd_data(rd_data),
		.strap_cfg(strap_cfg), .dram_ras_n(dram_ras_n),
		.dram_cas_n(dram_cas_n), .dram_we_n(dram_we_n),
		.dram_oe_n(dram_oe_n), .dram_addr(dram_addr), .md_in(md_in),
		.md_out(md_out), .md_oe(md_oe));

	vds_dram_model i_mem (.sys_clk(sys_clk), .ras_n(dram_ras_n),
		.cas_n(dram_cas_n), .we_n(dram_we_n), .oe_n(dram_oe_n),
		.addr(dram_addr), .din(md_out), .din_en(md_oe), .dq(mdl_q));

	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic summarize;
		$display("checks=%0d errors=%0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Lone read: one clock to the accepting edge, RAS-to-CAS, then CAS low; the word registers as CAS rises
	function automatic int rd_due(input int now);
		return now + cyc_min(T_RCD_X10) + cyc_min(T_CAS_LO_X10) + 1;
	endfunction

	// Ready is combinational, so it is judged mid-cycle before the edge
	task automatic xfer(input logic w, input logic [17:0] a,
		input logic [15:0] d, input logic iso);
		int n;
		n = 0;
		@(negedge sys_clk);
		req_valid = 1'b1;
		req_write = w;
		req_addr = a;
		req_wdata = d;
		#1;
		while (req_ready !== 1'b1 && n < 200) begin
			@(negedge sys_clk);
			#1;
			n++;
		end
		chk(n < 200, 1);
		if (w)
			ref_m[a] = d;
		else begin
			exp_q.push_back(ref_m[a]);
			lat_q.push_back(iso ? rd_due(cyc) : 0);
		end
		@(posedge sys_clk);
	endtask

	task automatic idle(input int n);
		@(negedge sys_clk);
		req_valid = 1'b0;
		repeat (n) @(negedge sys_clk);
	endtask

	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc > 30000) begin
			err_count++;
			summarize();
		end
	end

	// ------------------------------------------------------------
	// Pin timing and read data monitor
	// ------------------------------------------------------------
	always @(negedge sys_clk) begin
		if (rst_b) begin
			if (rd_valid === 1'b1) begin
				chk(exp_q.size() > 0, 1);
				chk(rd_data, exp_q.pop_front());
				if (lat_q[0] != 0)
					chk(cyc, lat_q[0]);
				void'(lat_q.pop_front());
			end
			if (!dram_ras_n && ras_q) begin
				chk(ras_hi >= 3, 1);
				if (!dram_cas_n) begin
					chk(cas_lo >= 1, 1);
					ref_p++;
				end
			end
			if (dram_ras_n && !ras_q)
				chk(ras_lo >= 4 && ras_lo <= PG, 1);
			if (!dram_cas_n && cas_q) begin
				chk(cas_hi >= 1, 1);
				if (!dram_ras_n) begin
					chk(ras_lo >= 3, 1);
					if (!dram_we_n)
						chk({we_q, md_oe}, 2'b01);
				end
			end
			if (dram_cas_n && !cas_q) begin
				chk(cas_lo >= 2, 1);
				if (!ras_q)
					chk(ras_lo >= 4, 1);
				if (ref_p != 0) begin
					chk(ref_p, REF_P);
					n_ref++;
					ref_p = 0;
				end
			end
		end
		ras_lo = dram_ras_n ? 0 : ras_lo + 1;
		ras_hi = dram_ras_n ? ras_hi + 1 : 0;
		cas_lo = dram_cas_n ? 0 : cas_lo + 1;
		cas_hi = dram_cas_n ? cas_hi + 1 : 0;
		ras_q = dram_ras_n;
		cas_q = dram_cas_n;
		we_q = dram_we_n;
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		logic [17:0] a;
		logic w;
		logic iso;
		void'($urandom(32'ha0e36a15));
		req_valid = 1'b0;
		req_write = 1'b0;
		req_addr = 18'h0;
		req_wdata = 16'h0;
		rst_b = 1'b0;
		strap_drv = 1'b1;
		strap = 16'($urandom);
		repeat (12) @(negedge sys_clk);
		chk({dram_ras_n, dram_cas_n, dram_we_n, dram_oe_n, md_oe}, 5'h1e);
		rst_b = 1'b1;
		repeat (2) @(negedge sys_clk);
		chk(strap_cfg, strap);
		strap_drv = 1'b0;
		repeat (12) @(negedge sys_clk);
		xfer(1'b1, 18'h3ffff, 16'hffff, 1'b0);
		idle(12);
		xfer(1'b0, 18'h3ffff, 16'h0, 1'b1);
		idle(12);
		// Page writes, then a read run long enough to hit the page limit
		for (int i = 0; i < 12; i++)
			xfer(1'b1, {9'h005, 9'(i)}, 16'($urandom), 1'b0);
		for (int i = 0; i < 30; i++)
			xfer(1'b0, {9'h005, 9'(i % 12)}, 16'h0, 1'b0);
		idle(12);
		iso = 1'b1;
		for (int i = 0; i < 300; i++) begin
			a = {8'h0, 1'($urandom), 9'($urandom % 8)};
			w = !ref_m.exists(a) || 1'($urandom);
			xfer(w, a, 16'($urandom), iso);
			iso = ($urandom % 4 == 0);
			if (iso)
				idle(12);
		end
		idle(30);
		chk(exp_q.size(), 0);
		chk(n_ref > 0, 1);
		summarize();
	end
endmodule
